// ### rtl/charger_ctrl.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
module charger_ctrl
    import charger_pkg::*;
#(
    parameter logic [31:0] BOOST_DELAY_CYC = 32'(BOOST_DELAY_CYCLES),
    parameter logic [47:0] WDT_UNIT_CYC = 48'(WDT_UNIT_CYCLES),
    parameter logic [47:0] SAFETY_CYC = 48'(SAFETY_CYCLES)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire sense_t sense,
    input wire logic charge_enable_pin_n,
    output logic [5:0] ilim_effective,
    output logic [5:0] vlim_effective,
    output logic converter_enable,
    output logic battery_switch_on,
    output logic pulse_mode_enable,
    output logic boost_active,
    output logic boost_current_high,
    output logic status_pin_drive,
    output logic int_pulse
);
    det_state_t det_state;
    chg_state_t chg_state;
    logic [5:0] input_current_limit;
    logic [5:0] input_voltage_limit;
    logic charge_enable_bit;
    logic light_load_pulse_mode_off;
    logic boost_enable_bit;
    logic boost_current_select;
    logic [1:0] watchdog_period;
    logic battery_switch_force_off;
    logic battery_switch_reset_enable;
    logic battery_switch_delay;
    logic recharge_threshold_select;
    logic [1:0] status_pin_mode;
    logic [1:0] vlimit_battery_offset;
    logic [5:0] charge_current_setting;
    logic [7:0] vreg_code;
    logic [7:0] iterm_code;
    logic [2:0] input_source_status;
    logic power_good;
    logic host_mode;
    logic safety_fault;
    logic [47:0] wdt_count;
    logic [47:0] safety_count;
    logic [31:0] boost_count;
    logic det_event;
    logic [5:0] det_limit;
    logic [2:0] det_source;
    logic wdt_expire;
    logic kick;
    logic charge_allowed;
    logic converter_on;
    logic can_start;
    logic terminate;
    logic above_recharge;
    logic boost_ok;
    logic [6:0] tracked;
    logic [5:0] next_vlim;
    logic [5:0] next_ilim;
    logic [1:0] charge_phase_status;

    wire write_ilim = wr && addr == ADDR_ILIM;
    wire write_vlim = wr && addr == ADDR_VLIM;
    wire write_ctrl = wr && addr == ADDR_CTRL;
    wire write_switch = wr && addr == ADDR_SWITCH;

    assign kick = write_ctrl && wdata[4];
    assign converter_on = det_state == DET_DONE && sense.source_present;
    assign charge_allowed = charge_enable_bit && !charge_enable_pin_n;
    // divider detection falls back to the unknown-adapter limit when no class matches
    always_comb begin
        det_event = 1'b0;
        det_limit = ILIM_UNKNOWN;
        det_source = SRC_UNKNOWN;
        if (det_state == DET_STANDARD && sense.std_done && !sense.dcd_timeout) begin
            det_event = 1'b1;
            if (sense.std_dcp) begin
                det_limit = ILIM_DCP;
                det_source = SRC_DCP;
            end else if (sense.std_sdp) begin
                det_limit = ILIM_SDP;
                det_source = SRC_SDP;
            end
        end else if (det_state == DET_DIVIDER) begin
            det_event = 1'b1;
            det_source = SRC_DIVIDER;
            if (sense.dp_level == LVL_2P7 && sense.dm_level == LVL_2P0) begin
                det_limit = ILIM_DIV1;
            end else if (sense.dp_level == LVL_1P2 && sense.dm_level == LVL_1P2) begin
                det_limit = ILIM_DIV2;
            end else if (sense.dp_level == LVL_2P0 && sense.dm_level == LVL_2P7) begin
                det_limit = ILIM_DIV3;
            end else if (sense.dp_level == LVL_2P7 && sense.dm_level == LVL_2P7) begin
                det_limit = ILIM_DIV4;
            end else begin
                det_limit = ILIM_UNKNOWN;
                det_source = SRC_UNKNOWN;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            det_state <= DET_IDLE;
        end else if (clk_en) begin
            if (!sense.source_present) begin
                det_state <= DET_IDLE;
            end else begin
                case (det_state)
                    DET_IDLE: det_state <= DET_STANDARD;
                    DET_STANDARD: begin
                        if (sense.dcd_timeout) begin
                            det_state <= DET_DIVIDER;
                        end else if (det_event) begin
                            det_state <= DET_DONE;
                        end
                    end
                    DET_DIVIDER: det_state <= DET_DONE;
                    DET_DONE: det_state <= DET_DONE;
                    default: det_state <= DET_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            input_source_status <= SRC_NONE;
            power_good <= 1'b0;
        end else if (clk_en) begin
            if (!sense.source_present) begin
                input_source_status <= boost_active ? SRC_BOOST : SRC_NONE;
                power_good <= 1'b0;
            end else if (det_event) begin
                input_source_status <= det_source;
                power_good <= 1'b1;
            end
        end
    end

    // watchdog: default mode after reset, kick enters host mode, period 00 never expires
    assign wdt_expire = host_mode && watchdog_period != 2'b00 && !kick
        && wdt_count >= 48'(watchdog_period) * WDT_UNIT_CYC;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            host_mode <= 1'b0;
            wdt_count <= '0;
        end else if (clk_en) begin
            if (kick) begin
                host_mode <= 1'b1;
                wdt_count <= '0;
            end else if (wdt_expire) begin
                host_mode <= 1'b0;
                wdt_count <= '0;
            end else if (host_mode && watchdog_period != 2'b00) begin
                wdt_count <= wdt_count + 48'h1;
            end
        end
    end

    // limits and battery switch settings survive a watchdog expiry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            input_current_limit <= ILIM_RESET;
            input_voltage_limit <= VLIM_RESET;
            battery_switch_force_off <= SWITCH_RESET[0];
            battery_switch_reset_enable <= SWITCH_RESET[1];
            battery_switch_delay <= SWITCH_RESET[2];
        end else if (clk_en) begin
            if (det_event) begin
                input_current_limit <= det_limit;
            end else if (write_ilim) begin
                input_current_limit <= wdata[5:0];
            end
            if (write_vlim) begin
                input_voltage_limit <= wdata[5:0];
            end
            if (write_switch) begin
                battery_switch_force_off <= wdata[0];
                battery_switch_reset_enable <= wdata[1];
                battery_switch_delay <= wdata[2];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            charge_enable_bit <= CTRL_RESET[0];
            light_load_pulse_mode_off <= CTRL_RESET[1];
            boost_enable_bit <= CTRL_RESET[2];
            boost_current_select <= CTRL_RESET[3];
            watchdog_period <= CTRL_RESET[6:5];
            recharge_threshold_select <= SWITCH_RESET[3];
            status_pin_mode <= SWITCH_RESET[5:4];
            vlimit_battery_offset <= SWITCH_RESET[7:6];
            charge_current_setting <= CHARGE_CURRENT_SETTING_RESET;
            vreg_code <= VREG_RESET;
            iterm_code <= ITERM_RESET;
        end else if (clk_en) begin
            if (wdt_expire) begin
                charge_enable_bit <= CTRL_RESET[0];
                light_load_pulse_mode_off <= CTRL_RESET[1];
                boost_enable_bit <= CTRL_RESET[2];
                boost_current_select <= CTRL_RESET[3];
                watchdog_period <= CTRL_RESET[6:5];
                recharge_threshold_select <= SWITCH_RESET[3];
                status_pin_mode <= SWITCH_RESET[5:4];
                vlimit_battery_offset <= SWITCH_RESET[7:6];
                charge_current_setting <= CHARGE_CURRENT_SETTING_RESET;
                vreg_code <= VREG_RESET;
                iterm_code <= ITERM_RESET;
            end else begin
                if (write_ctrl) begin
                    charge_enable_bit <= wdata[0];
                    light_load_pulse_mode_off <= wdata[1];
                    boost_enable_bit <= wdata[2];
                    boost_current_select <= wdata[3];
                    watchdog_period <= wdata[6:5];
                end
                if (write_switch) begin
                    recharge_threshold_select <= wdata[3];
                    status_pin_mode <= wdata[5:4];
                    vlimit_battery_offset <= wdata[7:6];
                end
                if (wr && addr == ADDR_CHARGE_CURRENT_SETTING) begin
                    charge_current_setting <= wdata[5:0];
                end
                if (wr && addr == ADDR_VREG) begin
                    vreg_code <= wdata;
                end
                if (wr && addr == ADDR_ITERM) begin
                    iterm_code <= wdata;
                end
            end
        end
    end

    // offset codes 01..11 add 200, 300, 400 mV
    assign tracked = {1'b0, sense.battery_voltage} + {5'h00, vlimit_battery_offset} + 7'h01;
    always_comb begin
        next_vlim = input_voltage_limit;
        if (vlimit_battery_offset != 2'b00 && tracked > {1'b0, input_voltage_limit}) begin
            next_vlim = tracked[6] ? 6'h3F : tracked[5:0];
        end
        next_ilim = input_current_limit;
        if (sense.sys_below_soft && input_current_limit > ILIM_SOFTSTART) begin
            next_ilim = ILIM_SOFTSTART;
        end
    end

    // boost qualification delay restarts whenever the enable bit drops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boost_count <= '0;
        end else if (clk_en) begin
            if (!boost_enable_bit) begin
                boost_count <= '0;
            end else if (boost_count < BOOST_DELAY_CYC) begin
                boost_count <= boost_count + 32'h1;
            end
        end
    end
    assign boost_ok = sense.battery_adequate && sense.input_sleep && boost_enable_bit
        && sense.boost_thermistor_ok && boost_count >= BOOST_DELAY_CYC;

    assign above_recharge = recharge_threshold_select ? sense.above_recharge_high
        : sense.above_recharge_low;
    assign can_start = converter_on && charge_allowed && charge_current_setting != 6'h00
        && sense.charge_thermistor_ok && !safety_fault && !battery_switch_force_off;
    assign terminate = sense.current_below_term && above_recharge
        && !sense.regulation_active;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chg_state <= CHG_OFF;
        end else if (clk_en) begin
            case (chg_state)
                CHG_OFF: begin
                    if (can_start) begin
                        chg_state <= sense.battery_below_fast ? CHG_PRE : CHG_FAST;
                    end
                end
                CHG_PRE: begin
                    if (!can_start) begin
                        chg_state <= CHG_OFF;
                    end else if (!sense.battery_below_fast) begin
                        chg_state <= CHG_FAST;
                    end
                end
                CHG_FAST: begin
                    if (!can_start) begin
                        chg_state <= CHG_OFF;
                    end else if (terminate) begin
                        chg_state <= CHG_DONE;
                    end
                end
                CHG_DONE: begin
                    if (!charge_allowed || !converter_on) begin
                        chg_state <= CHG_OFF;
                    end else if (!above_recharge) begin
                        chg_state <= CHG_OFF;
                    end
                end
                default: chg_state <= CHG_OFF;
            endcase
        end
    end

    always_comb begin
        case (chg_state)
            CHG_PRE: charge_phase_status = PHASE_PRE;
            CHG_FAST: charge_phase_status = PHASE_FAST;
            CHG_DONE: charge_phase_status = PHASE_DONE;
            default: charge_phase_status = PHASE_OFF;
        endcase
    end

    // safety fault is cleared only by taking charge enable away, so a retry needs a toggle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            safety_count <= '0;
            safety_fault <= 1'b0;
        end else if (clk_en) begin
            if (chg_state == CHG_PRE || chg_state == CHG_FAST) begin
                safety_count <= safety_count + 48'h1;
            end else begin
                safety_count <= '0;
            end
            if ((chg_state == CHG_PRE || chg_state == CHG_FAST)
                && safety_count >= SAFETY_CYC - 48'h1) begin
                safety_fault <= 1'b1;
            end else if (!charge_allowed) begin
                safety_fault <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ilim_effective <= ILIM_RESET;
            vlim_effective <= VLIM_RESET;
            converter_enable <= 1'b0;
            battery_switch_on <= 1'b1;
            pulse_mode_enable <= 1'b0;
            boost_active <= 1'b0;
            boost_current_high <= 1'b0;
            status_pin_drive <= 1'b0;
            int_pulse <= 1'b0;
        end else if (clk_en) begin
            ilim_effective <= next_ilim;
            vlim_effective <= next_vlim;
            converter_enable <= converter_on;
            battery_switch_on <= !battery_switch_force_off
                && (!converter_on || (charge_allowed && chg_state != CHG_DONE));
            pulse_mode_enable <= input_current_limit >= ILIM_PFM_MIN
                && !light_load_pulse_mode_off;
            boost_active <= boost_ok && !sense.source_present;
            boost_current_high <= boost_current_select;
            status_pin_drive <= status_pin_mode != 2'b11
                && (chg_state == CHG_PRE || chg_state == CHG_FAST);
            int_pulse <= det_event || (chg_state == CHG_FAST && can_start && terminate);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (clk_en) begin
            if (rd) begin
                case (addr)
                    ADDR_ILIM: rdata <= {2'b00, input_current_limit};
                    ADDR_VLIM: rdata <= {2'b00, input_voltage_limit};
                    ADDR_CTRL: rdata <= {1'b0, watchdog_period, 1'b0, boost_current_select,
                        boost_enable_bit, light_load_pulse_mode_off, charge_enable_bit};
                    ADDR_SWITCH: rdata <= {vlimit_battery_offset, status_pin_mode,
                        recharge_threshold_select, battery_switch_delay,
                        battery_switch_reset_enable, battery_switch_force_off};
                    ADDR_CHARGE_CURRENT_SETTING: rdata <= {2'b00, charge_current_setting};
                    ADDR_VREG: rdata <= vreg_code;
                    ADDR_ITERM: rdata <= iterm_code;
                    ADDR_STATUS: rdata <= {boost_active, !host_mode, power_good,
                        charge_phase_status, boost_active ? SRC_BOOST : input_source_status};
                    ADDR_STATUS2: rdata <= {3'b000, pulse_mode_enable, sense.sys_below_soft,
                        battery_switch_on, converter_enable, safety_fault};
                    default: rdata <= '0;
                endcase
            end else begin
                rdata <= '0;
            end
        end
    end
endmodule

// ### rtl/charger_pkg.sv
package charger_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    localparam logic [ADDR_W-1:0] ADDR_ILIM = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_VLIM = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_SWITCH = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_CHARGE_CURRENT_SETTING = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_VREG = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_ITERM = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS2 = 4'h9;

    // current limits in 100 mA steps, voltages in 100 mV steps
    localparam logic [5:0] ILIM_SDP = 6'h05;
    localparam logic [5:0] ILIM_DCP = 6'h18;
    localparam logic [5:0] ILIM_DIV1 = 6'h15;
    localparam logic [5:0] ILIM_DIV2 = 6'h14;
    localparam logic [5:0] ILIM_DIV3 = 6'h0A;
    localparam logic [5:0] ILIM_DIV4 = 6'h18;
    localparam logic [5:0] ILIM_UNKNOWN = 6'h05;
    localparam logic [5:0] ILIM_SOFTSTART = 6'h02;
    localparam logic [5:0] ILIM_PFM_MIN = 6'h05;
    localparam logic [5:0] ILIM_RESET = 6'h05;
    localparam logic [5:0] VLIM_RESET = 6'h2D;
    localparam logic [7:0] CTRL_RESET = 8'h21;
    localparam logic [7:0] SWITCH_RESET = 8'h02;
    localparam logic [5:0] CHARGE_CURRENT_SETTING_RESET = 6'h20;
    localparam logic [7:0] VREG_RESET = 8'h0B;
    localparam logic [7:0] ITERM_RESET = 8'h33;

    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_SDP = 3'h1;
    localparam logic [2:0] SRC_DCP = 3'h3;
    localparam logic [2:0] SRC_DIVIDER = 3'h5;
    localparam logic [2:0] SRC_UNKNOWN = 3'h6;
    localparam logic [2:0] SRC_BOOST = 3'h7;

    localparam logic [1:0] LVL_1P2 = 2'h1;
    localparam logic [1:0] LVL_2P0 = 2'h2;
    localparam logic [1:0] LVL_2P7 = 2'h3;

    localparam logic [1:0] PHASE_OFF = 2'h0;
    localparam logic [1:0] PHASE_PRE = 2'h1;
    localparam logic [1:0] PHASE_FAST = 2'h2;
    localparam logic [1:0] PHASE_DONE = 2'h3;

    localparam longint CLK_HZ = 100_000_000;
    localparam longint BOOST_DELAY_MS = 30;
    localparam longint BOOST_DELAY_CYCLES = BOOST_DELAY_MS * CLK_HZ / 1000;
    localparam longint WDT_UNIT_S = 40;
    localparam longint WDT_UNIT_CYCLES = WDT_UNIT_S * CLK_HZ;
    localparam longint SAFETY_HOURS = 10;
    localparam longint SAFETY_CYCLES = SAFETY_HOURS * 3600 * CLK_HZ;

    typedef enum logic [1:0] {
        DET_IDLE = 2'b00,
        DET_STANDARD = 2'b01,
        DET_DIVIDER = 2'b11,
        DET_DONE = 2'b10
    } det_state_t;

    typedef enum logic [1:0] {
        CHG_OFF = 2'b00,
        CHG_PRE = 2'b01,
        CHG_FAST = 2'b11,
        CHG_DONE = 2'b10
    } chg_state_t;

    typedef struct packed {
        logic source_present;
        logic std_done;
        logic std_dcp;
        logic std_sdp;
        logic dcd_timeout;
        logic [1:0] dp_level;
        logic [1:0] dm_level;
        logic battery_adequate;
        logic input_sleep;
        logic boost_thermistor_ok;
        logic charge_thermistor_ok;
        logic sys_below_soft;
        logic battery_below_fast;
        logic current_below_term;
        logic above_recharge_low;
        logic above_recharge_high;
        logic regulation_active;
        logic [5:0] battery_voltage;
    } sense_t;
endpackage

// ### sim/charger_ctrl_monitor.sv
module charger_ctrl_monitor
    import charger_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire sense_t sense,
    input wire logic charge_enable_pin_n,
    input wire logic [5:0] ilim_effective,
    input wire logic [5:0] vlim_effective,
    input wire logic converter_enable,
    input wire logic boost_active,
    input wire logic status_pin_drive,
    input wire logic int_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data present without a read");
    int_once_a: assert property (int_pulse |=> !int_pulse)
        else $error("interrupt longer than one cycle");
    soft_limit_a: assert property (sense.sys_below_soft [*2] |-> ilim_effective <= 6'h02)
        else $error("current limit above 200 mA with low rail");
    boost_cond_a: assert property ($rose(boost_active) |->
        $past(sense.battery_adequate && sense.input_sleep && sense.boost_thermistor_ok))
        else $error("boost started without its conditions");
    pin_block_a: assert property (charge_enable_pin_n [*3] |-> !status_pin_drive)
        else $error("charging with enable pin high");
    conv_block_a: assert property (!converter_enable [*3] |-> !status_pin_drive)
        else $error("charging with converter off");
    conv_source_a: assert property ($rose(converter_enable) |-> $past(sense.source_present))
        else $error("converter started without a source");
    reset_vlim_a: assert property (!$past(rstn) |-> vlim_effective == 6'h2D)
        else $error("voltage limit not 4.5 V after reset");
endmodule
bind charger_ctrl charger_ctrl_monitor u_charger_ctrl_monitor (.clk(clk), .rstn(rstn),
    .rd(rd), .rdata(rdata), .sense(sense), .charge_enable_pin_n(charge_enable_pin_n),
    .ilim_effective(ilim_effective), .vlim_effective(vlim_effective),
    .converter_enable(converter_enable), .boost_active(boost_active),
    .status_pin_drive(status_pin_drive), .int_pulse(int_pulse));

// ### sim/charger_ctrl_tb.sv
module charger_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import charger_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic plugged = 1'b0;
    logic charge_enable_pin_n = 1'b1;
    logic [2:0] kind = '0;
    logic [DATA_W-1:0] rdata;
    logic int_pulse;
    sense_t sense;
    int err_count = 0;
    int checked = 0;
    always #5 clk = ~clk;
    usb_source_model u_usb_source_model (.clk, .plugged, .kind, .sense);
    // clk_en held high: freezing is a power feature outside these scenarios
    charger_ctrl #(.BOOST_DELAY_CYC(32'hA), .WDT_UNIT_CYC(48'h32), .SAFETY_CYC(48'h64))
    u_charger_ctrl (.clk, .rstn, .clk_en(1'b1), .addr, .wdata, .wr, .rd, .rdata, .sense,
        .charge_enable_pin_n, .ilim_effective(), .vlim_effective(), .converter_enable(),
        .battery_switch_on(), .pulse_mode_enable(), .boost_active(), .boost_current_high(),
        .status_pin_drive(), .int_pulse);
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata & m);
    endtask
    task automatic plug(input logic [2:0] k);
        int n;
        @(posedge clk);
        plugged <= 1'b0;
        repeat (4) @(posedge clk);
        kind <= k;
        plugged <= 1'b1;
        for (n = 0; n < 40 && int_pulse !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("int_pulse", 8'h01, {7'h0, int_pulse});
        if (int_pulse !== 1'b1)
            results();
    endtask
    task automatic t_reset();
        logic [7:0] rv [7] = '{8'h05, 8'h2D, 8'h21, 8'h02, 8'h20, 8'h0B, 8'h33};
        for (int i = 0; i < 7; i++)
            rchk(4'(i), 8'hFF, rv[i]);
        rchk(ADDR_STATUS, 8'hFF, 8'h40);
        rchk(ADDR_STATUS2, 8'hFF, 8'h14);
        rchk(4'h7, 8'hFF, 8'h00);
    endtask
    task automatic t_detect();
        logic [5:0] lim [7] = '{6'h05, 6'h18, 6'h15, 6'h14, 6'h0A, 6'h18, 6'h05};
        logic [2:0] src [7] = '{3'h1, 3'h3, 3'h5, 3'h5, 3'h5, 3'h5, 3'h6};
        for (int k = 0; k < 7; k++) begin
            plug(3'(k));
            rchk(ADDR_ILIM, 8'h3F, {2'h0, lim[k]});
            rchk(ADDR_STATUS, 8'h27, {5'h04, src[k]});
        end
    endtask
    task automatic t_charge();
        @(posedge clk);
        charge_enable_pin_n <= 1'b0;
        repeat (10) @(posedge clk);
        rchk(ADDR_STATUS, 8'h18, 8'h10);
        @(posedge clk);
        charge_enable_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(ADDR_STATUS, 8'h18, 8'h00);
    endtask
    task automatic t_watchdog();
        wreg(ADDR_CTRL, 8'h31);
        wreg(ADDR_ILIM, 8'h04);
        rchk(ADDR_STATUS2, 8'h10, 8'h00);
        wreg(ADDR_ILIM, 8'h0C);
        wreg(ADDR_CHARGE_CURRENT_SETTING, 8'h10);
        rchk(ADDR_STATUS, 8'h40, 8'h00);
        repeat (60) @(posedge clk);
        rchk(ADDR_STATUS, 8'h40, 8'h40);
        rchk(ADDR_ILIM, 8'hFF, 8'h0C);
        rchk(ADDR_CHARGE_CURRENT_SETTING, 8'hFF, 8'h20);
        wreg(ADDR_CTRL, 8'h11);
        repeat (60) @(posedge clk);
        rchk(ADDR_STATUS, 8'h40, 8'h00);
        @(posedge clk);
        plugged <= 1'b0;
        wreg(ADDR_CTRL, 8'h05);
        rchk(ADDR_STATUS, 8'h80, 8'h00);
        repeat (20) @(posedge clk);
        rchk(ADDR_STATUS, 8'h87, 8'h87);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_detect();
        t_charge();
        t_watchdog();
        results();
    end
endmodule

// ### sim/usb_source_model.sv
module usb_source_model
    import charger_pkg::*;
(
    input wire logic clk,
    input wire logic plugged,
    input wire logic [2:0] kind,
    output sense_t sense
);
    timeunit 1ns;
    timeprecision 1ps;
    // kind: 0 sdp, 1 dcp, 2..5 divider one..four, 6 unknown; entry is {d+ window, d- window}
    localparam logic [3:0] LV [8] = '{4'h0, 4'h0, 4'hE, 4'h5, 4'hB, 4'hF, 4'h0, 4'h0};
    logic [3:0] age;
    always_ff @(posedge clk) age <= plugged ? age + {3'h0, age < 4'h8} : 4'h0;
    always_comb begin
        sense = '0;
        sense.source_present = plugged;
        sense.input_sleep = !plugged;
        sense.battery_adequate = 1'b1;
        sense.boost_thermistor_ok = 1'b1;
        sense.charge_thermistor_ok = 1'b1;
        sense.sys_below_soft = plugged && age < 4'h3;
        sense.battery_voltage = 6'h26;
        // detector results only settle a few cycles after plug-in, as on a real cable
        if (age > 4'h3) begin
            sense.std_done = kind < 3'h2;
            sense.std_dcp = kind == 3'h1;
            sense.std_sdp = kind == 3'h0;
            sense.dcd_timeout = kind > 3'h1;
            {sense.dp_level, sense.dm_level} = LV[kind];
        end
    end
endmodule
